/* File: pmc_pkg.sv */
package pmc_pkg;
  // Configuration byte addresses (48 and EC dword aligned, 4A is not)
  localparam logic [7:0]  PMC_ADDR_POWER_CS   = 8'h48;
  localparam logic [7:0]  PMC_ADDR_POWER_EXT  = 8'h4A;
  localparam logic [7:0]  PMC_ADDR_PHY_CTRL   = 8'hEC;
  localparam logic [7:0]  PMC_DWORD_MASK      = 8'hFC;

  // Control and status field positions
  localparam int          PMC_STS_BIT         = 15;
  localparam int          PMC_ENB_BIT         = 8;
  localparam int          PMC_STATE_LSB       = 0;
  localparam int          PMC_STATE_W         = 2;
  localparam int          PMC_EXT_LSB         = 16;

  // Byte lanes holding the writable control and status fields
  localparam int          PMC_BE_LOW          = 0;
  localparam int          PMC_BE_HIGH         = 1;

  // PHY control field positions
  localparam int          PMC_ROUTE_BIT       = 7;
  localparam int          PMC_COMPLY_BIT      = 3;
  localparam int          PMC_PHY_W           = 8;

  // Reset values
  localparam logic [15:0] PMC_POWER_CS_RST    = 16'h0000;
  localparam logic [15:0] PMC_POWER_EXT_VAL   = 16'h0000;
  localparam logic [7:0]  PMC_PHY_CTRL_RST    = 8'h08;

  // Serial EEPROM byte that preloads the PHY control register
  localparam logic [7:0]  PMC_EEPROM_PHY_BYTE = 8'h16;

  typedef enum logic [1:0] {
    PMC_D0 = 2'b00,
    PMC_D1 = 2'b01,
    PMC_D2 = 2'b10,
    PMC_D3 = 2'b11
  } pmc_state_t;
endpackage

/* File: pmc_regs.sv */
// How it works
// [RQ1] Wake events set status regardless of enable
// [RQ2] Writing one clears status and releases wake
// [RQ3] Enable bit gates the wake output
// [RQ4] Enable sticky if cold wake capable, else cleared
// [RQ5] Data scale and select read zero
// [RQ6] Middle reserved bits read zero
// [RQ7] Writable two-bit field selects power state
// [RQ8] Control and status survive D3hot internal reset
// [RQ9] Extension register reads zero, read-only
// [RQ10] Route bit drives inactivity indicator to pin
// [RQ11] EEPROM byte 16h bit 7 loads route bit
// [RQ12] Compliance bit resets to one, EEPROM keeps one
// [RQ13] EEPROM reserved bits must hold zero
// [RQ14] Upper PHY control bits read zero
// [RQ15] Cold wake capability decides enable stickiness
// [RQ16] Writes to read-only fields are ignored
`timescale 1ns/1ns
module pmc_regs (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           por_rst_i,
  input  wire logic                           d3hot_reset_i,
  input  wire logic                           cfg_req_i,
  input  wire logic                           cfg_we_i,
  input  wire logic [7:0]                     cfg_addr_i,
  input  wire logic [3:0]                     cfg_be_i,
  input  wire logic [31:0]                    cfg_wdata_i,
  output logic      [31:0]                    cfg_rdata_o,
  output logic                                cfg_ack_o,
  input  wire logic                           wake_event_i,
  input  wire logic                           cold_off_wake_capable_i,
  input  wire logic                           eeprom_load_i,
  input  wire logic [7:0]                     eeprom_byte_i,
  input  wire logic                           cable_inactivity_indicator_i,
  output logic                                inactivity_pin_o,
  output logic                                wake_pin_o,
  output logic                                wake_pin_oe_o,
  output pmc_pkg::pmc_state_t                 power_state_field_o
);
  import pmc_pkg::*;

  // Dword decode, so the low two address bits never matter
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] base);
    hit = (addr & PMC_DWORD_MASK) == (base & PMC_DWORD_MASK);
  endfunction

  logic                      wake_event_status_reg;
  logic                      wake_event_status_next;
  logic                      wake_assert_enable_reg;
  logic                      wake_assert_enable_next;
  pmc_state_t                power_state_field_reg;
  pmc_state_t                power_state_field_next;
  logic [PMC_PHY_W-1:0]      phy_ctrl_reg;
  logic [PMC_PHY_W-1:0]      phy_ctrl_next;
  logic [31:0]               rdata_reg;
  logic [31:0]               rdata_next;
  logic                      ack_reg;
  logic [2:0]                cna_sync_reg;
  logic                      cna_state_reg;
  logic                      cna_state_next;

  wire logic                 sel_power   = hit(cfg_addr_i, PMC_ADDR_POWER_CS);
  wire logic                 sel_phy     = hit(cfg_addr_i, PMC_ADDR_PHY_CTRL);
  wire logic                 wr_power    = cfg_req_i && cfg_we_i && sel_power;
  wire logic                 wr_phy      = cfg_req_i && cfg_we_i && sel_phy;
  wire logic                 rd_req      = cfg_req_i && !cfg_we_i;
  wire logic                 wr_low      = wr_power && cfg_be_i[PMC_BE_LOW];
  wire logic                 wr_high     = wr_power && cfg_be_i[PMC_BE_HIGH];
  wire logic                 sts_clear   = wr_high && cfg_wdata_i[PMC_STS_BIT];
  wire logic [15:0]          power_cs_rd;
  wire logic [31:0]          phy_rd;

  // [RQ5] [RQ6] Only status, enable and state bits are nonzero
  assign power_cs_rd = {wake_event_status_reg, 6'h00, wake_assert_enable_reg, 6'h00,
                        power_state_field_reg};
  // [RQ14] Upper PHY control bits are constant zero
  assign phy_rd      = {24'h000000, phy_ctrl_reg};

  // [RQ1] [RQ2] Set wins over a same-cycle clear
  assign wake_event_status_next = wake_event_i ? 1'b1 :
                                  sts_clear    ? 1'b0 : wake_event_status_reg;

  // [RQ4] [RQ15] Functional reset clears enable unless capable
  assign wake_assert_enable_next =
      (rst_i && !cold_off_wake_capable_i) ? 1'b0 :
      wr_high ? cfg_wdata_i[PMC_ENB_BIT] : wake_assert_enable_reg;

  // [RQ7] Power state is a plain writable field
  assign power_state_field_next =
      wr_low ? pmc_state_t'(cfg_wdata_i[PMC_STATE_LSB +: PMC_STATE_W]) : power_state_field_reg;

  // [RQ11] [RQ13] EEPROM preload takes the whole low byte
  // [RQ16] Host writes reach only the route bit
  always_comb begin
    phy_ctrl_next = phy_ctrl_reg;
    if (d3hot_reset_i) begin
      phy_ctrl_next = PMC_PHY_CTRL_RST;
    end else if (eeprom_load_i) begin
      phy_ctrl_next = eeprom_byte_i;
    end else if (wr_phy && cfg_be_i[PMC_BE_LOW]) begin
      phy_ctrl_next[PMC_ROUTE_BIT] = cfg_wdata_i[PMC_ROUTE_BIT];
    end
  end

  // [RQ9] Extension half of the dword is constant zero
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_req) begin
      if (sel_power) begin
        rdata_next = {PMC_POWER_EXT_VAL, power_cs_rd};
      end else if (sel_phy) begin
        rdata_next = phy_rd;
      end else begin
        rdata_next = 32'h00000000;
      end
    end
  end

  // Sticky wake bits sit on power-on reset so PCI reset keeps status, and keeps enable only if cold wake capable
  // [RQ8] D3hot internal reset leaves these untouched
  always_ff @(posedge clk_i or posedge por_rst_i) begin
    if (por_rst_i) begin
      wake_event_status_reg  <= PMC_POWER_CS_RST[PMC_STS_BIT];
      wake_assert_enable_reg <= PMC_POWER_CS_RST[PMC_ENB_BIT];
    end else begin
      wake_event_status_reg  <= wake_event_status_next;
      wake_assert_enable_reg <= wake_assert_enable_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      power_state_field_reg <= PMC_D0;
    end else begin
      power_state_field_reg <= power_state_field_next;
    end
  end

  // [RQ12] Compliance bit comes up as one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phy_ctrl_reg <= PMC_PHY_CTRL_RST;
    end else begin
      phy_ctrl_reg <= phy_ctrl_next;
    end
  end

  // Writes are acked too, so the host never waits on a missing answer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h00000000;
      ack_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg   <= cfg_req_i;
    end
  end

  // Indicator comes from the PHY side, so it is synchronised
  assign cna_state_next = (cna_sync_reg[1] == cna_sync_reg[2]) ? cna_sync_reg[1]
                                                               : cna_state_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cna_sync_reg  <= 3'h0;
      cna_state_reg <= 1'b0;
    end else begin
      cna_sync_reg  <= {cna_sync_reg[1:0], cable_inactivity_indicator_i};
      cna_state_reg <= cna_state_next;
    end
  end

  assign cfg_rdata_o         = rdata_reg;
  assign cfg_ack_o           = ack_reg;
  assign power_state_field_o = power_state_field_reg;
  // [RQ10] Route bit gates the indicator onto its pin
  assign inactivity_pin_o    = phy_ctrl_reg[PMC_ROUTE_BIT] & cna_state_reg;
  // [RQ3] Open-drain wake: pull low only while enabled
  assign wake_pin_o          = 1'b0;
  assign wake_pin_oe_o       = wake_event_status_reg & wake_assert_enable_reg;

  a_status_set: assert property ( // [RQ1]
    @(posedge clk_i) disable iff (por_rst_i)
    wake_event_i |=> wake_event_status_reg)
    else $error("wake event did not set status");

  a_status_clear: assert property ( // [RQ2]
    @(posedge clk_i) disable iff (por_rst_i)
    (sts_clear && !wake_event_i) |=> (!wake_event_status_reg && !wake_pin_oe_o))
    else $error("status clear did not release wake");

  a_status_hold: assert property ( // [RQ2]
    @(posedge clk_i) disable iff (por_rst_i)
    (!wake_event_i && !sts_clear) |=> $stable(wake_event_status_reg))
    else $error("status changed without cause");

  a_wake_gate: assert property ( // [RQ3]
    @(posedge clk_i) disable iff (por_rst_i)
    wake_pin_oe_o == (wake_event_status_reg && wake_assert_enable_reg))
    else $error("wake output not gated by enable");

  a_enable_sticky: assert property ( // [RQ4]
    @(posedge clk_i) disable iff (por_rst_i)
    (rst_i && cold_off_wake_capable_i) |=> $stable(wake_assert_enable_reg))
    else $error("sticky enable lost on reset");

  a_enable_cleared: assert property ( // [RQ15]
    @(posedge clk_i) disable iff (por_rst_i)
    (rst_i && !cold_off_wake_capable_i) |=> !wake_assert_enable_reg)
    else $error("enable not cleared by reset");

  a_reserved_zero: assert property ( // [RQ6]
    @(posedge clk_i) disable iff (rst_i)
    (ack_reg && $past(rd_req) && $past(sel_power)) |->
      (cfg_rdata_o[31:16] == 16'h0000 && cfg_rdata_o[14:9] == 6'h00
       && cfg_rdata_o[7:2] == 6'h00))
    else $error("reserved or extension bits read nonzero");

  a_state_write: assert property ( // [RQ7]
    @(posedge clk_i) disable iff (rst_i)
    wr_low |=> power_state_field_o == $past(cfg_wdata_i[1:0]))
    else $error("power state write not taken");

  a_d3hot_keep: assert property ( // [RQ8]
    @(posedge clk_i) disable iff (rst_i)
    (d3hot_reset_i && !wr_power) |=> $stable(power_state_field_reg))
    else $error("state disturbed by internal reset");

  a_route_pin: assert property ( // [RQ10]
    @(posedge clk_i) disable iff (rst_i)
    !phy_ctrl_reg[PMC_ROUTE_BIT] |-> !inactivity_pin_o)
    else $error("indicator driven while not routed");

  a_eeprom_load: assert property ( // [RQ11]
    @(posedge clk_i) disable iff (rst_i)
    (eeprom_load_i && !d3hot_reset_i) |=> phy_ctrl_reg == $past(eeprom_byte_i))
    else $error("EEPROM preload not taken");

  a_phy_upper: assert property ( // [RQ14]
    @(posedge clk_i) disable iff (rst_i)
    (ack_reg && $past(rd_req) && $past(sel_phy)) |-> cfg_rdata_o[31:8] == 24'h000000)
    else $error("upper PHY bits read nonzero");

  a_ro_ignored: assert property ( // [RQ16]
    @(posedge clk_i) disable iff (rst_i)
    (wr_phy && !eeprom_load_i && !d3hot_reset_i) |=>
      phy_ctrl_reg[6:0] == $past(phy_ctrl_reg[6:0]))
    else $error("read-only PHY bits changed by write");

  a_wake_fire: assert property ( // [RQ3]
    @(posedge clk_i) disable iff (por_rst_i)
    (wake_event_i && wake_assert_enable_reg && !wr_high && !rst_i) |=> wake_pin_oe_o)
    else $error("enabled wake event did not drive wake");

  a_status_keep: assert property ( // [RQ2]
    @(posedge clk_i) disable iff (por_rst_i)
    (wr_high && !cfg_wdata_i[PMC_STS_BIT] && !wake_event_i) |=> $stable(wake_event_status_reg))
    else $error("writing zero changed status");

  a_data_zero: assert property ( // [RQ5]
    @(posedge clk_i) disable iff (rst_i)
    (ack_reg && $past(rd_req) && $past(sel_power)) |->
      cfg_rdata_o[14:9] == 6'h00)
    else $error("data scale or select read nonzero");

  a_ext_zero: assert property ( // [RQ9]
    @(posedge clk_i) disable iff (rst_i)
    (ack_reg && $past(rd_req) && $past(sel_power)) |->
      cfg_rdata_o[31:16] == 16'h0000)
    else $error("extension register read nonzero");

  a_comply_load: assert property ( // [RQ12]
    @(posedge clk_i) disable iff (rst_i)
    d3hot_reset_i |=> phy_ctrl_reg == PMC_PHY_CTRL_RST)
    else $error("PHY control not reinitialised");

  a_enable_write: assert property ( // [RQ3]
    @(posedge clk_i) disable iff (por_rst_i)
    (wr_high && !rst_i) |=> wake_assert_enable_reg == $past(cfg_wdata_i[PMC_ENB_BIT]))
    else $error("enable write not taken");

  a_route_write: assert property ( // [RQ10]
    @(posedge clk_i) disable iff (rst_i)
    (wr_phy && cfg_be_i[PMC_BE_LOW] && !eeprom_load_i && !d3hot_reset_i) |=>
      phy_ctrl_reg[PMC_ROUTE_BIT] == $past(cfg_wdata_i[PMC_ROUTE_BIT]))
    else $error("route bit write not taken");

  a_route_follow: assert property ( // [RQ10]
    @(posedge clk_i) disable iff (rst_i)
    (cna_sync_reg[1] && cna_sync_reg[2] && phy_ctrl_reg[PMC_ROUTE_BIT]
     && !wr_phy && !d3hot_reset_i && !eeprom_load_i) |=> inactivity_pin_o)
    else $error("routed indicator not on pin");

  a_d3hot_enable: assert property ( // [RQ8]
    @(posedge clk_i) disable iff (por_rst_i)
    (d3hot_reset_i && !wr_high && !rst_i) |=> $stable(wake_assert_enable_reg))
    else $error("enable disturbed by internal reset");

  a_unmapped_zero: assert property ( // [RQ16]
    @(posedge clk_i) disable iff (rst_i)
    (ack_reg && $past(rd_req) && !$past(sel_power) && !$past(sel_phy)) |->
      cfg_rdata_o == 32'h00000000)
    else $error("unmapped read nonzero");
endmodule

/* File: pmc_eeprom_model.sv */
`timescale 1ns/1ns
module pmc_eeprom_model (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic       route_i,
  output logic            load_o,
  output logic      [7:0] byte_o
);
  logic [7:0] image;
  // Route bit 7, bit 3 set, reserved zero
  assign image = {route_i, 3'h0, 1'b1, 3'h0};
  always @(posedge clk_i) begin
    load_o <= start_i;
    // Inverse outside a load so stale data never looks valid
    byte_o <= start_i ? image : ~image;
  end
endmodule

/* File: tb.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  import pmc_pkg::*;
  logic        clk, rst, por, d3h, req, we, wake, cold, cable_inactivity_indicator, ee_start, ee_route;
  logic [7:0]  addr, ee_byte;
  logic [3:0]  be;
  logic [31:0] wdata, rdata;
  logic        ack, ee_load, inact, wake_o, wake_oe;
  pmc_state_t  state;
  int          failures = 0;
  int          total_checks = 0;
  localparam logic [1:0] P_WAKE = 2'h0;
  localparam logic [1:0] P_D3H  = 2'h1;
  localparam logic [1:0] P_EE   = 2'h2;

  pmc_regs pmc_regs_inst (.clk_i(clk), .rst_i(rst), .por_rst_i(por), .d3hot_reset_i(d3h),
    .cfg_req_i(req), .cfg_we_i(we), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata),
    .cfg_rdata_o(rdata), .cfg_ack_o(ack), .wake_event_i(wake),
    .cold_off_wake_capable_i(cold), .eeprom_load_i(ee_load), .eeprom_byte_i(ee_byte),
    .cable_inactivity_indicator_i(cable_inactivity_indicator), .inactivity_pin_o(inact), .wake_pin_o(wake_o),
    .wake_pin_oe_o(wake_oe), .power_state_field_o(state));
  pmc_eeprom_model pmc_eeprom_model_inst (.clk_i(clk), .start_i(ee_start),
    .route_i(ee_route), .load_o(ee_load), .byte_o(ee_byte));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    addr <= a;
    be <= b;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    #1;
    `CHK(ack, 1'b1)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 4'hF, 32'h0000_0000);
    `CHK(rdata, e)
  endtask

  task automatic pulse(input logic [1:0] sel);
    @(posedge clk);
    case (sel)
      P_WAKE: wake <= 1'b1;
      P_D3H: d3h <= 1'b1;
      default: ee_start <= 1'b1;
    endcase
    @(posedge clk);
    {wake, d3h, ee_start} <= 3'h0;
    @(posedge clk);
  endtask

  task automatic bus_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Whole run is under a hundred cycles
  initial begin
    #1000000;
    failures++;
    tally_and_finish;
  end

  initial begin
    {rst, por, d3h, req, we, wake, cold, cable_inactivity_indicator, ee_start, ee_route} = 10'h300;
    addr = 8'h00;
    be = 4'h0;
    wdata = 32'h0000_0000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    rd(PMC_ADDR_POWER_CS, 32'h0000_0000);
    rd(PMC_ADDR_PHY_CTRL, 32'h0000_0008);
    rd(8'h40, 32'h0000_0000);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, PMC_ADDR_POWER_CS, 4'h1, {30'h0, i[1:0]});
      `CHK(state, pmc_state_t'(i))
    end
    xfer(1'b1, PMC_ADDR_POWER_CS, 4'h3, 32'hFFFF_FFFF);
    rd(PMC_ADDR_POWER_EXT, 32'h0000_0103);
    $display("power state done");
    pulse(P_WAKE);
    rd(PMC_ADDR_POWER_CS, 32'h0000_8103);
    `CHK(wake_oe, 1'b1)
    `CHK(wake_o, 1'b0)
    xfer(1'b1, PMC_ADDR_POWER_CS, 4'h2, 32'h0000_0100);
    rd(PMC_ADDR_POWER_CS, 32'h0000_8103);
    xfer(1'b1, PMC_ADDR_POWER_CS, 4'h2, 32'h0000_8000);
    rd(PMC_ADDR_POWER_CS, 32'h0000_0003);
    `CHK(wake_oe, 1'b0)
    pulse(P_WAKE);
    rd(PMC_ADDR_POWER_CS, 32'h0000_8003);
    `CHK(wake_oe, 1'b0)
    xfer(1'b1, PMC_ADDR_POWER_CS, 4'h2, 32'h0000_8100);
    rd(PMC_ADDR_POWER_CS, 32'h0000_0103);
    // Event and clear in one cycle: the event must win
    fork
      pulse(P_WAKE);
      xfer(1'b1, PMC_ADDR_POWER_CS, 4'h2, 32'h0000_8100);
    join
    rd(PMC_ADDR_POWER_CS, 32'h0000_8103);
    `CHK(wake_oe, 1'b1)
    xfer(1'b1, PMC_ADDR_POWER_CS, 4'h2, 32'h0000_8100);
    rd(PMC_ADDR_POWER_CS, 32'h0000_0103);
    $display("wake done");
    xfer(1'b1, PMC_ADDR_PHY_CTRL, 4'hF, 32'hFFFF_FF80);
    rd(PMC_ADDR_PHY_CTRL, 32'h0000_0088);
    @(posedge clk);
    cable_inactivity_indicator <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    `CHK(inact, 1'b1)
    pulse(P_D3H);
    rd(PMC_ADDR_POWER_CS, 32'h0000_0103);
    rd(PMC_ADDR_PHY_CTRL, 32'h0000_0008);
    `CHK(inact, 1'b0)
    @(posedge clk);
    ee_route <= 1'b1;
    pulse(P_EE);
    @(posedge clk);
    rd(PMC_ADDR_PHY_CTRL, 32'h0000_0088);
    $display("phy control done");
    @(posedge clk);
    cold <= 1'b1;
    bus_reset;
    rd(PMC_ADDR_POWER_CS, 32'h0000_0100);
    @(posedge clk);
    cold <= 1'b0;
    bus_reset;
    rd(PMC_ADDR_POWER_CS, 32'h0000_0000);
    $display("sticky enable done");
    tally_and_finish;
  end
endmodule
